// [logic/dwsb_pkg.sv]
// constants shared by the drive warning status bank and its testbench
package dwsb_pkg;

  localparam int unsigned WORD_W = 16;

  // fieldbus parameter addresses
  localparam logic [WORD_W-1:0] ADDR_HOMING = 16'h062c;
  localparam logic [WORD_W-1:0] ADDR_ACTIVE = 16'h1c16;
  localparam logic [WORD_W-1:0] ADDR_SAVED  = 16'h1c18;

  // warning bit positions, shared by both warning words
  localparam int unsigned BIT_GENERAL      = 0;
  localparam int unsigned BIT_STAGE_TEMP   = 1;
  localparam int unsigned BIT_MOTOR_TEMP   = 2;
  localparam int unsigned BIT_RSVD_LOW     = 3;
  localparam int unsigned BIT_STAGE_OVLD   = 4;
  localparam int unsigned BIT_MOTOR_OVLD   = 5;
  localparam int unsigned BIT_BRAKE_OVLD   = 6;
  localparam int unsigned BIT_CAN          = 7;
  localparam int unsigned BIT_ENCODER      = 8;
  localparam int unsigned BIT_RS485        = 9;
  localparam int unsigned BIT_TORQUE_OFF   = 10;
  localparam int unsigned BIT_UNDERVOLT    = 11;
  localparam int unsigned BIT_PROFIBUS     = 12;
  localparam int unsigned BIT_CAPTURE      = 13;
  localparam int unsigned BIT_ETHERNET     = 14;
  localparam int unsigned BIT_RSVD_HIGH    = 15;

  localparam logic [WORD_W-1:0] ONE_HOT     = 16'h0001;
  localparam logic [WORD_W-1:0] RESERVED_MASK =
    (ONE_HOT << BIT_RSVD_LOW) | (ONE_HOT << BIT_RSVD_HIGH);
  localparam logic [WORD_W-1:0] AUTO_CLEAR_MASK =
    (ONE_HOT << BIT_TORQUE_OFF) | (ONE_HOT << BIT_UNDERVOLT) | (ONE_HOT << BIT_CAPTURE);

  // homing-before-absolute-move register
  localparam int unsigned        HOMING_FLAG_BIT = 0;
  localparam logic               HOMING_RESET    = 1'b0;
  localparam logic [WORD_W-2:0]  HOMING_PAD      = 15'h0000;
  localparam logic [WORD_W-1:0]  WORD_ZERO       = 16'h0000;

endpackage : dwsb_pkg

// [logic/dwsb_sync.sv]
// three-stage synchroniser for the raw warning sources
`timescale 1ns/10ps
`default_nettype none
module dwsb_sync (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              nrst,
  // raw warning levels from outside the clock domain
  input  wire logic [15:0]       rawWarn,
  // filtered warning levels
  output var  logic [15:0]       stableWarn
);

  typedef struct packed {
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] s3;
    logic [15:0] stable;
  } dwsb_sync_state_t;

  dwsb_sync_state_t st_ff;
  dwsb_sync_state_t nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = rawWarn;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // a bit moves only once stages two and three agree, so a lone glitch is dropped
    nxt_st.stable = (st_ff.s2 & ~(st_ff.s2 ^ st_ff.s3)) | (st_ff.stable & (st_ff.s2 ^ st_ff.s3));
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign stableWarn = st_ff.stable;

endmodule : dwsb_sync
`default_nettype wire

// [logic/dwsb_bank.sv]
// drive warning status bank: active and saved warning words, homing-before-absolute-move flag
`timescale 1ns/10ps
`default_nettype none
module dwsb_bank (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              nrst,
  // warning sources, asynchronous levels
  input  wire logic              warnGeneral,
  input  wire logic              warnStageTemp,
  input  wire logic              warnMotorTemp,
  input  wire logic              warnStageOverload,
  input  wire logic              warnMotorOverload,
  input  wire logic              warnBrakeOverload,
  input  wire logic              warnCan,
  input  wire logic              warnEncoder,
  input  wire logic              warnRs485,
  input  wire logic              torqueOffInputA,
  input  wire logic              torqueOffInputB,
  input  wire logic              warnUndervoltage,
  input  wire logic              warnProfibus,
  input  wire logic              warnCaptureBusy,
  input  wire logic              warnEthernet,
  // fault clear, one-cycle pulse from drive control
  input  wire logic              faultClearCommand,
  // parameter access port
  input  wire logic              paramRead,
  input  wire logic              paramWrite,
  input  wire logic [15:0]       paramAddr,
  input  wire logic [15:0]       paramWdata,
  output var  logic [15:0]       paramRdata,
  output var  logic              paramAck,
  output var  logic              paramErr,
  // absolute move gate
  input  wire logic              absMoveReq,
  input  wire logic              homingDone,
  output var  logic              absMoveGo,
  output var  logic              absMoveRefused,
  // warning words and homing flag for local use
  output var  logic [15:0]       activeWarningWord,
  output var  logic [15:0]       savedWarningWord,
  output var  logic              homingBeforeAbsoluteMove
);

  typedef struct packed {
    logic [15:0] active;
    logic [15:0] saved;
    logic        homing;
    logic [15:0] rdata;
    logic        ack;
    logic        err;
    logic        absGo;
    logic        absRefused;
  } dwsb_bank_state_t;

  dwsb_bank_state_t st_ff;
  dwsb_bank_state_t nxt_st;
  logic [15:0]      rawWarn;
  logic [15:0]      syncWarn;

  function automatic logic dwsb_hit(input logic [15:0] addr, input logic [15:0] target);
    dwsb_hit = (addr == target);
  endfunction : dwsb_hit

  always_comb begin
    rawWarn = dwsb_pkg::WORD_ZERO;
    rawWarn[dwsb_pkg::BIT_GENERAL]    = warnGeneral;
    rawWarn[dwsb_pkg::BIT_STAGE_TEMP] = warnStageTemp;
    rawWarn[dwsb_pkg::BIT_MOTOR_TEMP] = warnMotorTemp;
    rawWarn[dwsb_pkg::BIT_STAGE_OVLD] = warnStageOverload;
    rawWarn[dwsb_pkg::BIT_MOTOR_OVLD] = warnMotorOverload;
    rawWarn[dwsb_pkg::BIT_BRAKE_OVLD] = warnBrakeOverload;
    rawWarn[dwsb_pkg::BIT_CAN]        = warnCan;
    rawWarn[dwsb_pkg::BIT_ENCODER]    = warnEncoder;
    rawWarn[dwsb_pkg::BIT_RS485]      = warnRs485;
    rawWarn[dwsb_pkg::BIT_TORQUE_OFF] = torqueOffInputA | torqueOffInputB;
    rawWarn[dwsb_pkg::BIT_UNDERVOLT]  = warnUndervoltage;
    rawWarn[dwsb_pkg::BIT_PROFIBUS]   = warnProfibus;
    rawWarn[dwsb_pkg::BIT_CAPTURE]    = warnCaptureBusy;
    rawWarn[dwsb_pkg::BIT_ETHERNET]   = warnEthernet;
  end

  // sources come from other clock domains and from pins
  dwsb_sync u_sync (
    .clock      (clock),
    .nrst       (nrst),
    .rawWarn    (rawWarn),
    .stableWarn (syncWarn)
  );

  always_comb begin
    nxt_st            = st_ff;
    nxt_st.ack        = 1'b0;
    nxt_st.err        = 1'b0;
    nxt_st.absGo      = 1'b0;
    nxt_st.absRefused = 1'b0;

    nxt_st.active = syncWarn & ~dwsb_pkg::RESERVED_MASK;

    if (faultClearCommand) begin
      nxt_st.saved = dwsb_pkg::WORD_ZERO;
    end
    nxt_st.saved = nxt_st.saved & ~dwsb_pkg::AUTO_CLEAR_MASK;
    nxt_st.saved = nxt_st.saved | nxt_st.active;

    if (paramRead) begin
      nxt_st.ack   = 1'b1;
      nxt_st.rdata = dwsb_pkg::WORD_ZERO;
      if (dwsb_hit(paramAddr, dwsb_pkg::ADDR_ACTIVE)) begin
        nxt_st.rdata = st_ff.active;
      end else if (dwsb_hit(paramAddr, dwsb_pkg::ADDR_SAVED)) begin
        nxt_st.rdata = st_ff.saved;
      end else if (dwsb_hit(paramAddr, dwsb_pkg::ADDR_HOMING)) begin
        nxt_st.rdata = {dwsb_pkg::HOMING_PAD, st_ff.homing};
      end else begin
        nxt_st.err = 1'b1;
      end
    end else if (paramWrite) begin
      nxt_st.ack = 1'b1;
      if (dwsb_hit(paramAddr, dwsb_pkg::ADDR_HOMING)) begin
        nxt_st.homing = paramWdata[dwsb_pkg::HOMING_FLAG_BIT];
      end else begin
        nxt_st.err = 1'b1;
      end
    end

    if (absMoveReq) begin
      if (st_ff.homing && !homingDone) begin
        nxt_st.absRefused = 1'b1;
      end else begin
        nxt_st.absGo = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_ff        <= '0;
      st_ff.homing <= dwsb_pkg::HOMING_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign paramRdata               = st_ff.rdata;
  assign paramAck                 = st_ff.ack;
  assign paramErr                 = st_ff.err;
  assign absMoveGo                = st_ff.absGo;
  assign absMoveRefused           = st_ff.absRefused;
  assign activeWarningWord        = st_ff.active;
  assign savedWarningWord         = st_ff.saved;
  assign homingBeforeAbsoluteMove = st_ff.homing;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_readActive;
    paramRead && paramAddr == dwsb_pkg::ADDR_ACTIVE;
  endsequence

  sequence s_readSaved;
    paramRead && paramAddr == dwsb_pkg::ADDR_SAVED;
  endsequence

  sequence s_blockedMove;
    absMoveReq && st_ff.homing && !homingDone;
  endsequence

  a_active_tracks_sources: assert property (
    activeWarningWord == ($past(syncWarn) & ~dwsb_pkg::RESERVED_MASK)
  ) else $error("active word does not follow the synchronised sources");

  a_reserved_bits_zero: assert property (
    ((activeWarningWord | savedWarningWord) & dwsb_pkg::RESERVED_MASK) == dwsb_pkg::WORD_ZERO
  ) else $error("reserved warning bit set");

  a_saved_covers_active: assert property (
    (activeWarningWord & ~savedWarningWord) == dwsb_pkg::WORD_ZERO
  ) else $error("active bit without its saved bit");

  a_saved_stays_set: assert property (
    !faultClearCommand |=>
      (($past(savedWarningWord) & ~dwsb_pkg::AUTO_CLEAR_MASK) & ~savedWarningWord) == dwsb_pkg::WORD_ZERO
  ) else $error("saved bit dropped without fault clear");

  a_fault_clear_wipes: assert property (
    faultClearCommand |=> savedWarningWord == activeWarningWord
  ) else $error("fault clear left stale saved bits");

  a_auto_bits_follow: assert property (
    (savedWarningWord & dwsb_pkg::AUTO_CLEAR_MASK) == (activeWarningWord & dwsb_pkg::AUTO_CLEAR_MASK)
  ) else $error("self-clearing saved bit disagrees with active bit");

  a_read_saved_word: assert property (
    s_readSaved |=> paramAck && !paramErr && paramRdata == $past(savedWarningWord)
  ) else $error("saved word read returned wrong data");

  a_read_active_word: assert property (
    s_readActive |=> paramAck && !paramErr && paramRdata == $past(activeWarningWord)
  ) else $error("active word read returned wrong data");

  a_move_refused: assert property (
    s_blockedMove |=> absMoveRefused && !absMoveGo
  ) else $error("absolute move passed before homing");

  a_move_allowed: assert property (
    absMoveReq && !st_ff.homing |=> absMoveGo && !absMoveRefused
  ) else $error("absolute move refused with homing flag clear");

endmodule : dwsb_bank
`default_nettype wire

// [tb/dwsb_master.sv]
// fieldbus master model: one strobed access per call on the parameter port
`timescale 1ns/10ps
`default_nettype none
module dwsb_master (
  // clock
  input  wire logic        clock,
  // request side
  output var  logic        paramRead,
  output var  logic        paramWrite,
  output var  logic [15:0] paramAddr,
  output var  logic [15:0] paramWdata,
  // answer side
  input  wire logic [15:0] paramRdata,
  input  wire logic        paramAck,
  input  wire logic        paramErr
);
  initial begin
    paramRead = 1'b0;
    paramWrite = 1'b0;
    paramAddr = 16'h0000;
    paramWdata = 16'h0000;
  end
  task automatic xfer(input logic w, input logic [15:0] a, d, output logic [15:0] rd, output logic ak, er);
    @(posedge clock);
    paramRead <= ~w;
    paramWrite <= w;
    paramAddr <= a;
    paramWdata <= d;
    @(posedge clock);
    paramRead <= 1'b0;
    paramWrite <= 1'b0;
    // released lines show the inverse so stale values never look valid
    paramAddr <= ~a;
    paramWdata <= ~d;
    @(negedge clock);
    rd = paramRdata;
    ak = paramAck;
    er = paramErr;
  endtask : xfer
endmodule : dwsb_master
`default_nettype wire

// [tb/dwsb_bank_tb_top.sv]
// testbench for the drive warning status bank
`timescale 1ns/10ps
`default_nettype none
module dwsb_bank_tb_top;
  logic        clock, nrst, clr, mvReq, hDone, pRd, pWr, pAck, pErr, go, refused, flag, ack, err;
  logic [15:0] ws, pAddr, pWd, pRdata, actW, savW, rd, expA, expS;
  int          badCount, comparisons, cycles;
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // bit 3 of ws feeds the second torque-off input, which maps onto bit 10
  dwsb_bank i_dut (.clock(clock), .nrst(nrst), .warnGeneral(ws[0]), .warnStageTemp(ws[1]),
    .warnMotorTemp(ws[2]), .warnStageOverload(ws[4]), .warnMotorOverload(ws[5]),
    .warnBrakeOverload(ws[6]), .warnCan(ws[7]), .warnEncoder(ws[8]), .warnRs485(ws[9]),
    .torqueOffInputA(ws[10]), .torqueOffInputB(ws[3]), .warnUndervoltage(ws[11]),
    .warnProfibus(ws[12]), .warnCaptureBusy(ws[13]), .warnEthernet(ws[14]),
    .faultClearCommand(clr), .paramRead(pRd), .paramWrite(pWr), .paramAddr(pAddr),
    .paramWdata(pWd), .paramRdata(pRdata), .paramAck(pAck), .paramErr(pErr),
    .absMoveReq(mvReq), .homingDone(hDone), .absMoveGo(go), .absMoveRefused(refused),
    .activeWarningWord(actW), .savedWarningWord(savW), .homingBeforeAbsoluteMove(flag));
  dwsb_master i_master (.clock(clock), .paramRead(pRd), .paramWrite(pWr), .paramAddr(pAddr),
    .paramWdata(pWd), .paramRdata(pRdata), .paramAck(pAck), .paramErr(pErr));
  task automatic tallyAndFinish;
    if (badCount == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tallyAndFinish
  task automatic chk(input string nm, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      badCount++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [15:0] a, d, e, input logic ee);
    i_master.xfer(w, a, d, rd, ack, err);
    chk("paramAck", 16'h0001, {15'h0000, ack});
    chk("paramErr", {15'h0000, ee}, {15'h0000, err});
    if (!w) chk("paramRdata", e, rd);
  endtask : acc
  task automatic mv(input logic eGo);
    @(posedge clock) mvReq <= 1'b1;
    @(posedge clock) mvReq <= 1'b0;
    @(negedge clock);
    chk("absMoveGo", {15'h0000, eGo}, {15'h0000, go});
    chk("absMoveRefused", {15'h0000, ~eGo}, {15'h0000, refused});
  endtask : mv
  task automatic settle(input logic [15:0] v);
    @(posedge clock) ws <= v;
    // three sync stages, the filter stage and the word register, with margin
    repeat (6) @(posedge clock);
  endtask : settle
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      badCount++;
      tallyAndFinish();
    end
  end
  initial begin
    nrst = 1'b0;
    ws = 16'h0000;
    clr = 1'b0;
    mvReq = 1'b0;
    hDone = 1'b0;
    badCount = 0;
    comparisons = 0;
    cycles = 0;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    acc(1'b0, dwsb_pkg::ADDR_HOMING, 16'h0000, 16'h0000, 1'b0);
    acc(1'b0, dwsb_pkg::ADDR_ACTIVE, 16'h0000, 16'h0000, 1'b0);
    acc(1'b0, dwsb_pkg::ADDR_SAVED, 16'h0000, 16'h0000, 1'b0);
    acc(1'b1, dwsb_pkg::ADDR_SAVED, 16'hffff, 16'h0000, 1'b1);
    acc(1'b1, dwsb_pkg::ADDR_ACTIVE, 16'hffff, 16'h0000, 1'b1);
    acc(1'b0, dwsb_pkg::ADDR_SAVED, 16'h0000, 16'h0000, 1'b0);
    acc(1'b0, 16'h0000, 16'h0000, 16'h0000, 1'b1);
    acc(1'b1, dwsb_pkg::ADDR_HOMING, 16'hffff, 16'h0000, 1'b0);
    chk("homingBeforeAbsoluteMove", 16'h0001, {15'h0000, flag});
    acc(1'b0, dwsb_pkg::ADDR_HOMING, 16'h0000, 16'h0001, 1'b0);
    mv(1'b0);
    @(posedge clock) hDone <= 1'b1;
    mv(1'b1);
    acc(1'b1, dwsb_pkg::ADDR_HOMING, 16'h0000, 16'h0000, 1'b0);
    chk("homingBeforeAbsoluteMove", 16'h0000, {15'h0000, flag});
    @(posedge clock) hDone <= 1'b0;
    mv(1'b1);
    expS = 16'h0000;
    // one source at a time: mapping, persistence and self-clearing bits
    for (int i = 0; i < 15; i++) begin
      settle(dwsb_pkg::ONE_HOT << i);
      expA = (i == 3) ? 16'h0400 : dwsb_pkg::ONE_HOT << i;
      expS = (expS & ~dwsb_pkg::AUTO_CLEAR_MASK) | expA;
      acc(1'b0, dwsb_pkg::ADDR_ACTIVE, 16'h0000, expA, 1'b0);
      acc(1'b0, dwsb_pkg::ADDR_SAVED, 16'h0000, expS, 1'b0);
      chk("savedWarningWord", expS, savW);
    end
    settle(16'h7fff);
    acc(1'b0, dwsb_pkg::ADDR_ACTIVE, 16'h0000, 16'h7ff7, 1'b0);
    chk("activeWarningWord", 16'h7ff7, actW);
    settle(16'h0000);
    acc(1'b0, dwsb_pkg::ADDR_SAVED, 16'h0000, 16'h53f7, 1'b0);
    settle(16'h0001);
    @(posedge clock) clr <= 1'b1;
    @(posedge clock) clr <= 1'b0;
    acc(1'b0, dwsb_pkg::ADDR_SAVED, 16'h0000, 16'h0001, 1'b0);
    tallyAndFinish();
  end
endmodule : dwsb_bank_tb_top
`default_nettype wire
